// file: design/bffm_top.sv
// Top of the bidirectional FIFO block: port decode, offsets, mailboxes, data out
//
// Summary of operation
// - Nearly-full flag timed by writing port clock
// - Separate full offsets, preset or loaded via A
// - Nearly-full low at count >= depth minus offset
// - Nearly-full high at count <= depth-offset-1
// - Output register word not counted as stored
// - Nearly-full release on second writing-port edge
// - Edge coincident with read not first sync
// - One 36-bit mailbox per direction
// - Mail select high picks mailbox, low FIFO
// - Port A mail write stores A bus
// - Port B mail write stores B bus
// - Mailbox write drives its free flag low
// - Writes ignored while mailbox is occupied
// - Enabled outputs show FIFO or mailbox data
// - Port B mail read frees first mailbox
// - Port A mail read frees second mailbox
// - Mailbox reads leave contents intact
// - First word falls through in three edges
// - Space flag returns after read, synchronised
// - Nearly-empty rises after write, synchronised
// - Reset presets second FIFO offsets too
// - No space: space flag low, writes dropped
// - Nearly-empty low at count <= empty offset
`timescale 1ns/100ps
`default_nettype none
module bffm_top
    import bffm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic offset_program_mode,
    input wire logic port_a_clock,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_direction,
    input wire logic port_a_transfer_strobe,
    input wire logic port_a_mail_select,
    input wire logic [DATA_W-1:0] port_a_data_bus_in,
    output logic [DATA_W-1:0] port_a_data_bus_out,
    output logic port_a_data_bus_oe,
    input wire logic port_b_clock,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_direction,
    input wire logic port_b_transfer_strobe,
    input wire logic port_b_mail_select,
    input wire logic [DATA_W-1:0] port_b_data_bus_in,
    output logic [DATA_W-1:0] port_b_data_bus_out,
    output logic port_b_data_bus_oe,
    output logic fifo1_space_flag,
    output logic fifo1_nearly_full_flag_n,
    output logic fifo1_has_data_flag,
    output logic fifo1_nearly_empty_flag_n,
    output logic fifo2_space_flag,
    output logic fifo2_nearly_full_flag_n,
    output logic fifo2_has_data_flag,
    output logic fifo2_nearly_empty_flag_n,
    output logic mailbox1_free_flag,
    output logic mailbox2_free_flag
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] a_ctl_s1_reg;
    logic [4:0] a_ctl_s2_reg;
    logic [4:0] b_ctl_s1_reg;
    logic [4:0] b_ctl_s2_reg;
    logic [DATA_W-1:0] a_data_s1_reg;
    logic [DATA_W-1:0] a_data_s2_reg;
    logic [DATA_W-1:0] b_data_s1_reg;
    logic [DATA_W-1:0] b_data_s2_reg;
    logic prog_s1_reg;
    logic prog_s2_reg;
    logic a_clk_last_reg;
    logic b_clk_last_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            a_ctl_s1_reg <= 5'h01;
            a_ctl_s2_reg <= 5'h01;
            b_ctl_s1_reg <= 5'h01;
            b_ctl_s2_reg <= 5'h01;
        end else begin
            a_ctl_s1_reg <= {port_a_clock, port_a_direction, port_a_transfer_strobe,
                             port_a_mail_select, port_a_chip_select_n};
            a_ctl_s2_reg <= a_ctl_s1_reg;
            b_ctl_s1_reg <= {port_b_clock, port_b_direction, port_b_transfer_strobe,
                             port_b_mail_select, port_b_chip_select_n};
            b_ctl_s2_reg <= b_ctl_s1_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            a_data_s1_reg <= MAIL_RESET;
            a_data_s2_reg <= MAIL_RESET;
            b_data_s1_reg <= MAIL_RESET;
            b_data_s2_reg <= MAIL_RESET;
        end else begin
            a_data_s1_reg <= port_a_data_bus_in;
            a_data_s2_reg <= a_data_s1_reg;
            b_data_s1_reg <= port_b_data_bus_in;
            b_data_s2_reg <= b_data_s1_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prog_s1_reg <= 1'b0;
            prog_s2_reg <= 1'b0;
        end else begin
            prog_s1_reg <= offset_program_mode;
            prog_s2_reg <= prog_s1_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            a_clk_last_reg <= 1'b0;
            b_clk_last_reg <= 1'b0;
        end else begin
            a_clk_last_reg <= a_ctl_s2_reg[4];
            b_clk_last_reg <= b_ctl_s2_reg[4];
        end
    end

    // ------------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------------
    logic a_edge;
    logic a_sel;
    logic a_write;
    logic a_read;
    logic a_mail;
    logic b_edge;
    logic b_sel;
    logic b_write;
    logic b_read;
    logic b_mail;
    logic a_fifo_wr;
    logic a_fifo_rd;
    logic a_mail_wr;
    logic a_mail_rd;
    logic b_fifo_wr;
    logic b_fifo_rd;
    logic b_mail_wr;
    logic b_mail_rd;

    always_comb begin
        a_edge = a_ctl_s2_reg[4] && !a_clk_last_reg;
        a_sel = !a_ctl_s2_reg[0];
        a_write = a_ctl_s2_reg[3];
        a_read = !a_ctl_s2_reg[3];
        a_mail = a_ctl_s2_reg[1];
        b_edge = b_ctl_s2_reg[4] && !b_clk_last_reg;
        b_sel = !b_ctl_s2_reg[0];
        b_write = !b_ctl_s2_reg[3];
        b_read = b_ctl_s2_reg[3];
        b_mail = b_ctl_s2_reg[1];
    end

    always_comb begin
        a_fifo_wr = a_edge && a_sel && a_write && a_ctl_s2_reg[2] && !a_mail;
        a_mail_wr = a_edge && a_sel && a_write && a_ctl_s2_reg[2] && a_mail;
        a_fifo_rd = a_edge && a_sel && a_read && a_ctl_s2_reg[2] && !a_mail;
        a_mail_rd = a_edge && a_sel && a_read && a_ctl_s2_reg[2] && a_mail;
        b_fifo_wr = b_edge && b_sel && b_write && b_ctl_s2_reg[2] && !b_mail;
        b_mail_wr = b_edge && b_sel && b_write && b_ctl_s2_reg[2] && b_mail;
        b_fifo_rd = b_edge && b_sel && b_read && b_ctl_s2_reg[2] && !b_mail;
        b_mail_rd = b_edge && b_sel && b_read && b_ctl_s2_reg[2] && b_mail;
    end

    // ------------------------------------------------------------------
    // Offset registers
    // ------------------------------------------------------------------
    bffm_prog_t prog_reg;
    bffm_prog_t prog_next;
    logic prog_active;
    logic [OFS_W-1:0] fifo1_empty_offset_reg;
    logic [OFS_W-1:0] fifo1_full_offset_reg;
    logic [OFS_W-1:0] fifo2_empty_offset_reg;
    logic [OFS_W-1:0] fifo2_full_offset_reg;

    always_comb begin
        prog_active = prog_s2_reg && (prog_reg != PROG_DONE);
        prog_next = prog_reg;
        if (prog_active && a_fifo_wr) begin
            case (prog_reg)
                PROG_EMPTY1: prog_next = PROG_FULL1;
                PROG_FULL1: prog_next = PROG_EMPTY2;
                PROG_EMPTY2: prog_next = PROG_FULL2;
                PROG_FULL2: prog_next = PROG_DONE;
                default: prog_next = PROG_DONE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prog_reg <= PROG_EMPTY1;
        end else begin
            prog_reg <= prog_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fifo1_empty_offset_reg <= EMPTY_OFFSET_PRESET;
            fifo1_full_offset_reg <= FULL_OFFSET_PRESET;
            fifo2_empty_offset_reg <= EMPTY_OFFSET_PRESET;
            fifo2_full_offset_reg <= FULL_OFFSET_PRESET;
        end else if (prog_active && a_fifo_wr) begin
            case (prog_reg)
                PROG_EMPTY1: fifo1_empty_offset_reg <= a_data_s2_reg[OFS_W-1:0];
                PROG_FULL1: fifo1_full_offset_reg <= a_data_s2_reg[OFS_W-1:0];
                PROG_EMPTY2: fifo2_empty_offset_reg <= a_data_s2_reg[OFS_W-1:0];
                PROG_FULL2: fifo2_full_offset_reg <= a_data_s2_reg[OFS_W-1:0];
                default: fifo1_empty_offset_reg <= fifo1_empty_offset_reg;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // FIFO1: port A to port B
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] fifo1_out_data;

    bffm_fifo_dir u_fifo1 (
        .clock(clock),
        .rst(rst),
        .wr_edge(a_edge),
        .wr_req(a_fifo_wr && !prog_active),
        .wr_data(a_data_s2_reg),
        .rd_edge(b_edge),
        .rd_req(b_fifo_rd),
        .empty_offset(fifo1_empty_offset_reg),
        .full_offset(fifo1_full_offset_reg),
        .space_flag(fifo1_space_flag),
        .nearly_full_flag_n(fifo1_nearly_full_flag_n),
        .has_data_flag(fifo1_has_data_flag),
        .nearly_empty_flag_n(fifo1_nearly_empty_flag_n),
        .out_data(fifo1_out_data)
    );

    // ------------------------------------------------------------------
    // FIFO2: port B to port A
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] fifo2_out_data;

    bffm_fifo_dir u_fifo2 (
        .clock(clock),
        .rst(rst),
        .wr_edge(b_edge),
        .wr_req(b_fifo_wr),
        .wr_data(b_data_s2_reg),
        .rd_edge(a_edge),
        .rd_req(a_fifo_rd),
        .empty_offset(fifo2_empty_offset_reg),
        .full_offset(fifo2_full_offset_reg),
        .space_flag(fifo2_space_flag),
        .nearly_full_flag_n(fifo2_nearly_full_flag_n),
        .has_data_flag(fifo2_has_data_flag),
        .nearly_empty_flag_n(fifo2_nearly_empty_flag_n),
        .out_data(fifo2_out_data)
    );

    // ------------------------------------------------------------------
    // Mailbox 1: port A to port B
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mail1_reg;
    logic mail1_accept;

    always_comb begin
        mail1_accept = a_mail_wr && mailbox1_free_flag;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mail1_reg <= MAIL_RESET;
        end else if (mail1_accept) begin
            mail1_reg <= a_data_s2_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mailbox1_free_flag <= 1'b1;
        end else if (mail1_accept) begin
            mailbox1_free_flag <= 1'b0;
        end else if (b_mail_rd) begin
            mailbox1_free_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mailbox 2: port B to port A
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mail2_reg;
    logic mail2_accept;

    always_comb begin
        mail2_accept = b_mail_wr && mailbox2_free_flag;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mail2_reg <= MAIL_RESET;
        end else if (mail2_accept) begin
            mail2_reg <= b_data_s2_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mailbox2_free_flag <= 1'b1;
        end else if (mail2_accept) begin
            mailbox2_free_flag <= 1'b0;
        end else if (a_mail_rd) begin
            mailbox2_free_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Data outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            port_a_data_bus_out <= MAIL_RESET;
            port_b_data_bus_out <= MAIL_RESET;
        end else begin
            port_a_data_bus_out <= a_mail ? mail2_reg : fifo2_out_data;
            port_b_data_bus_out <= b_mail ? mail1_reg : fifo1_out_data;
        end
    end

    always_comb begin
        port_a_data_bus_oe = a_sel && a_read;
        port_b_data_bus_oe = b_sel && b_read;
    end

endmodule // bffm_top
`default_nettype wire

// file: design/bffm_pkg.sv
// Shared constants and types for the bidirectional FIFO flag and mailbox block
package bffm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int ADDR_W = 8;
    localparam int PTR_W = 9;
    localparam int OFS_W = 8;
    localparam int DEPTH_WORDS = 256;
    localparam logic [PTR_W-1:0] DEPTH = 9'h100;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [OFS_W-1:0] EMPTY_OFFSET_PRESET = 8'h08;
    localparam logic [OFS_W-1:0] FULL_OFFSET_PRESET = 8'h08;
    localparam logic [DATA_W-1:0] MAIL_RESET = 36'h000000000;
    localparam logic [PTR_W-1:0] PTR_RESET = 9'h000;

    // ------------------------------------------------------------------
    // Offset loading sequence
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PROG_EMPTY1,
        PROG_FULL1,
        PROG_EMPTY2,
        PROG_FULL2,
        PROG_DONE
    } bffm_prog_t;

    // ------------------------------------------------------------------
    // Pointer encoding
    // ------------------------------------------------------------------
    function automatic logic [PTR_W-1:0] bffm_bin_to_gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] bffm_gray_to_bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// file: design/bffm_fifo_dir.sv
// One direction of the FIFO: storage, pointers, level flags and fall-through
`timescale 1ns/100ps
`default_nettype none
module bffm_fifo_dir
    import bffm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_edge,
    input wire logic wr_req,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_edge,
    input wire logic rd_req,
    input wire logic [OFS_W-1:0] empty_offset,
    input wire logic [OFS_W-1:0] full_offset,
    output logic space_flag,
    output logic nearly_full_flag_n,
    output logic has_data_flag,
    output logic nearly_empty_flag_n,
    output logic [DATA_W-1:0] out_data
);

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:DEPTH_WORDS-1];
    logic [PTR_W-1:0] wptr_reg;
    logic [PTR_W-1:0] rptr_reg;
    logic [PTR_W-1:0] rgray_s1_reg;
    logic [PTR_W-1:0] rgray_s2_reg;
    logic [PTR_W-1:0] wgray_s1_reg;
    logic [PTR_W-1:0] wgray_s2_reg;
    logic [PTR_W-1:0] wptr_next;
    logic [PTR_W-1:0] rptr_next;
    logic [PTR_W-1:0] wr_count_next;
    logic [PTR_W-1:0] rd_count_next;
    logic wr_accept;
    logic rd_take;
    logic mem_avail;
    logic load;

    always_comb begin
        wr_accept = wr_edge && wr_req && space_flag;
        wptr_next = wr_accept ? wptr_reg + 9'h001 : wptr_reg;
        wr_count_next = wptr_next - bffm_gray_to_bin(wr_edge ? rgray_s1_reg : rgray_s2_reg);
        rd_take = rd_edge && rd_req && has_data_flag;
        mem_avail = bffm_gray_to_bin(wgray_s2_reg) != rptr_reg;
        load = rd_edge && mem_avail && (!has_data_flag || rd_take);
        rptr_next = load ? rptr_reg + 9'h001 : rptr_reg;
        rd_count_next = bffm_gray_to_bin(rd_edge ? wgray_s1_reg : wgray_s2_reg) - rptr_next;
    end

    always_ff @(posedge clock) begin
        if (wr_accept) begin
            mem[wptr_reg[ADDR_W-1:0]] <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Writing side
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            wptr_reg <= PTR_RESET;
            rgray_s1_reg <= PTR_RESET;
            rgray_s2_reg <= PTR_RESET;
            space_flag <= 1'b1;
            nearly_full_flag_n <= 1'b1;
        end else if (wr_edge) begin
            wptr_reg <= wptr_next;
            rgray_s1_reg <= bffm_bin_to_gray(rptr_reg);
            rgray_s2_reg <= rgray_s1_reg;
            space_flag <= wr_count_next < DEPTH;
            nearly_full_flag_n <= wr_count_next < (DEPTH - {1'b0, full_offset});
        end
    end

    // ------------------------------------------------------------------
    // Reading side
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rptr_reg <= PTR_RESET;
            wgray_s1_reg <= PTR_RESET;
            wgray_s2_reg <= PTR_RESET;
            has_data_flag <= 1'b0;
            nearly_empty_flag_n <= 1'b0;
            out_data <= MAIL_RESET;
        end else if (rd_edge) begin
            rptr_reg <= rptr_next;
            wgray_s1_reg <= bffm_bin_to_gray(wptr_reg);
            wgray_s2_reg <= wgray_s1_reg;
            nearly_empty_flag_n <= rd_count_next > {1'b0, empty_offset};
            if (load) begin
                out_data <= mem[rptr_reg[ADDR_W-1:0]];
                has_data_flag <= 1'b1;
            end else if (rd_take) begin
                has_data_flag <= 1'b0;
            end
        end
    end

endmodule // bffm_fifo_dir
`default_nettype wire

// file: sim/bffm_checker.sv
// Concurrent checks on the ports of the FIFO flag and mailbox block
`timescale 1ns/100ps
`default_nettype none
module bffm_checker
    import bffm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic port_a_clock,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_direction,
    input wire logic port_a_transfer_strobe,
    input wire logic port_a_mail_select,
    input wire logic port_a_data_bus_oe,
    input wire logic port_b_clock,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_direction,
    input wire logic port_b_transfer_strobe,
    input wire logic port_b_mail_select,
    input wire logic [DATA_W-1:0] port_b_data_bus_out,
    input wire logic fifo1_space_flag,
    input wire logic fifo1_nearly_full_flag_n,
    input wire logic fifo1_has_data_flag,
    input wire logic fifo1_nearly_empty_flag_n,
    input wire logic mailbox1_free_flag,
    input wire logic mailbox2_free_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----
    // Mailbox operations at the pins
    // ----
    logic a_mw, b_mw, b_mr;
    assign a_mw = !port_a_chip_select_n && port_a_transfer_strobe && port_a_direction
        && port_a_mail_select;
    assign b_mw = !port_b_chip_select_n && port_b_transfer_strobe && !port_b_direction
        && port_b_mail_select;
    assign b_mr = !port_b_chip_select_n && port_b_transfer_strobe && port_b_direction
        && port_b_mail_select;
    // ----
    // Assertions
    // ----
    chk_mail1_store: assert property (
        $rose(port_a_clock) && a_mw |-> ##3 !mailbox1_free_flag)
        else $error("mailbox 1 not marked full");
    chk_mail2_store: assert property (
        $rose(port_b_clock) && b_mw |-> ##3 !mailbox2_free_flag)
        else $error("mailbox 2 not marked full");
    chk_mail1_free: assert property (
        $rose(port_b_clock) && b_mr && !($rose(port_a_clock) && a_mw)
        |-> ##3 mailbox1_free_flag) else $error("mailbox 1 not freed");
    chk_mail_hold: assert property (
        (!mailbox1_free_flag && port_b_mail_select)[*6] |-> $stable(port_b_data_bus_out))
        else $error("held mail changed");
    chk_oe_read: assert property (
        (!rst && !port_a_chip_select_n && !port_a_direction)[*5] |-> port_a_data_bus_oe)
        else $error("port A outputs off during read");
    chk_full_sync: assert property (
        $rose(fifo1_nearly_full_flag_n) |-> $past(port_a_clock, 3) && !$past(port_a_clock, 4))
        else $error("nearly full released off port A edge");
    chk_space_sync: assert property (
        $rose(fifo1_space_flag) |-> $past(port_a_clock, 3) && !$past(port_a_clock, 4))
        else $error("space raised off port A edge");
    chk_ready_sync: assert property (
        $rose(fifo1_has_data_flag) |-> $past(port_b_clock, 3) && !$past(port_b_clock, 4))
        else $error("data ready raised off port B edge");
    chk_empty_sync: assert property (
        $rose(fifo1_nearly_empty_flag_n) |-> $past(port_b_clock, 3) && !$past(port_b_clock, 4))
        else $error("nearly empty released off port B edge");
endmodule // bffm_checker
bind bffm_top bffm_checker i_chk (.clock, .rst, .port_a_clock, .port_a_chip_select_n,
    .port_a_direction, .port_a_transfer_strobe, .port_a_mail_select, .port_a_data_bus_oe,
    .port_b_clock, .port_b_chip_select_n, .port_b_direction, .port_b_transfer_strobe,
    .port_b_mail_select, .port_b_data_bus_out, .fifo1_space_flag, .fifo1_nearly_full_flag_n,
    .fifo1_has_data_flag, .fifo1_nearly_empty_flag_n, .mailbox1_free_flag, .mailbox2_free_flag);
`default_nettype wire

// file: sim/bffm_port_master.sv
// Synchronous bus master model driving one port of the block
`timescale 1ns/100ps
`default_nettype none
module bffm_port_master
    import bffm_pkg::*;
#(
    parameter logic WR = 1'h1
)
(
    input wire logic clock,
    output logic pclk,
    output logic cs_n,
    output logic dir,
    output logic stb,
    output logic mail,
    output logic [DATA_W-1:0] data
);
    initial begin
        pclk = 1'h0;
        cs_n = 1'h1;
        dir = ~WR;
        stb = 1'h0;
        mail = 1'h0;
        data = '0;
    end
    // ----
    // One port clock cycle: ctl is select, write, strobe, mail select
    // ----
    task automatic cyc(input logic [3:0] ctl, input logic [DATA_W-1:0] d);
        @(posedge clock);
        cs_n <= ~ctl[3];
        dir <= ctl[2] ? WR : ~WR;
        stb <= ctl[1];
        mail <= ctl[0];
        data <= d;
        repeat (3) @(posedge clock);
        pclk <= 1'h1;
        repeat (4) @(posedge clock);
        pclk <= 1'h0;
        repeat (3) @(posedge clock);
        stb <= 1'h0;
        data <= ~d;
    endtask
endmodule // bffm_port_master
`default_nettype wire

// file: sim/tb_bidir_fifo_flags_mailbox.sv
// Self-checking bench for the FIFO flag and mailbox block
`timescale 1ns/100ps
`default_nettype none
module tb_bidir_fifo_flags_mailbox
    import bffm_pkg::*;
;
    logic clock, rst, offset_program_mode;
    logic port_a_clock, port_a_chip_select_n, port_a_direction, port_a_transfer_strobe;
    logic port_a_mail_select, port_a_data_bus_oe, port_b_clock, port_b_chip_select_n;
    logic port_b_direction, port_b_transfer_strobe, port_b_mail_select, port_b_data_bus_oe;
    logic [DATA_W-1:0] port_a_data_bus_in, port_a_data_bus_out;
    logic [DATA_W-1:0] port_b_data_bus_in, port_b_data_bus_out;
    logic fifo1_space_flag, fifo1_nearly_full_flag_n, fifo1_has_data_flag;
    logic fifo1_nearly_empty_flag_n, fifo2_space_flag, fifo2_nearly_full_flag_n;
    logic fifo2_has_data_flag, fifo2_nearly_empty_flag_n, mailbox1_free_flag, mailbox2_free_flag;
    int failures = 0, n_compared = 0;

    bffm_top i_dut (.clock, .rst, .offset_program_mode, .port_a_clock, .port_a_chip_select_n,
        .port_a_direction, .port_a_transfer_strobe, .port_a_mail_select, .port_a_data_bus_in,
        .port_a_data_bus_out, .port_a_data_bus_oe, .port_b_clock, .port_b_chip_select_n,
        .port_b_direction, .port_b_transfer_strobe, .port_b_mail_select, .port_b_data_bus_in,
        .port_b_data_bus_out, .port_b_data_bus_oe, .fifo1_space_flag, .fifo1_nearly_full_flag_n,
        .fifo1_has_data_flag, .fifo1_nearly_empty_flag_n, .fifo2_space_flag,
        .fifo2_nearly_full_flag_n, .fifo2_has_data_flag, .fifo2_nearly_empty_flag_n,
        .mailbox1_free_flag, .mailbox2_free_flag);
    bffm_port_master #(.WR(1'h1)) i_a (.clock, .pclk(port_a_clock),
        .cs_n(port_a_chip_select_n), .dir(port_a_direction), .stb(port_a_transfer_strobe),
        .mail(port_a_mail_select), .data(port_a_data_bus_in));
    bffm_port_master #(.WR(1'h0)) i_b (.clock, .pclk(port_b_clock),
        .cs_n(port_b_chip_select_n), .dir(port_b_direction), .stb(port_b_transfer_strobe),
        .mail(port_b_mail_select), .data(port_b_data_bus_in));

    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    // ----
    // Compare and port helpers
    // ----
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chkd(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input bit d, input logic [DATA_W-1:0] v);
        if (d) i_b.cyc(4'he, v);
        else i_a.cyc(4'he, v);
    endtask
    task automatic rd(input bit d);
        if (d) i_a.cyc(4'ha, '0);
        else i_b.cyc(4'ha, '0);
    endtask
    task automatic idle(input bit d);
        if (d) i_a.cyc(4'h8, '0);
        else i_b.cyc(4'h8, '0);
    endtask
    function automatic logic ne(input bit d);
        return d ? fifo2_nearly_empty_flag_n : fifo1_nearly_empty_flag_n;
    endfunction
    task automatic do_reset;
        @(posedge clock);
        rst <= 1'h1;
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        repeat (3) @(posedge clock);
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        chk(fifo1_space_flag & fifo2_space_flag, 1'h1);
        chk(fifo1_nearly_full_flag_n & fifo2_nearly_full_flag_n, 1'h1);
        chk(fifo1_has_data_flag, 1'h0);
        chk(fifo1_nearly_empty_flag_n, 1'h0);
        chk(mailbox1_free_flag & mailbox2_free_flag, 1'h1);
    endtask
    task automatic t_mail;
        i_a.cyc(4'hf, 36'h123456789);
        chk(mailbox1_free_flag, 1'h0);
        i_a.cyc(4'hf, 36'h0aaaaaaaa);
        i_b.cyc(4'hb, '0);
        chkd(port_b_data_bus_out, 36'h123456789);
        chk(port_b_data_bus_oe, 1'h1);
        chk(mailbox1_free_flag, 1'h1);
        i_b.cyc(4'h9, '0);
        chkd(port_b_data_bus_out, 36'h123456789);
        i_b.cyc(4'hf, 36'h0fedcba98);
        chk(mailbox2_free_flag, 1'h0);
        chk(port_b_data_bus_oe, 1'h0);
        i_a.cyc(4'hb, '0);
        chkd(port_a_data_bus_out, 36'h0fedcba98);
        chk(mailbox2_free_flag, 1'h1);
    endtask
    task automatic t_ne(input bit d, input int x);
        for (int i = 0; i <= x; i++) wr(d, DATA_W'(i));
        repeat (2) idle(d);
        chk(d ? fifo2_has_data_flag : fifo1_has_data_flag, 1'h0);
        idle(d);
        chk(d ? fifo2_has_data_flag : fifo1_has_data_flag, 1'h1);
        chkd(d ? port_a_data_bus_out : port_b_data_bus_out, '0);
        chk(ne(d), 1'h0);
        wr(d, 36'h0ff);
        idle(d);
        chk(ne(d), 1'h0);
        idle(d);
        chk(ne(d), 1'h1);
    endtask
    task automatic t_full(input int c, input int y);
        for (int i = c; i < 255 - y; i++) wr(0, DATA_W'(i));
        chk(fifo1_nearly_full_flag_n, 1'h1);
        wr(0, 36'h0);
        chk(fifo1_nearly_full_flag_n, 1'h0);
        for (int i = 256 - y; i < 256; i++) wr(0, DATA_W'(i));
        chk(fifo1_space_flag, 1'h0);
        wr(0, 36'h0);
        rd(0);
        chkd(port_b_data_bus_out, 36'h1);
        idle(1);
        chk(fifo1_space_flag, 1'h0);
        idle(1);
        chk(fifo1_space_flag, 1'h1);
        repeat (y) rd(0);
        idle(1);
        chk(fifo1_nearly_full_flag_n, 1'h0);
        idle(1);
        chk(fifo1_nearly_full_flag_n, 1'h1);
    endtask
    task automatic t_prog;
        @(posedge clock);
        offset_program_mode <= 1'h1;
        do_reset;
        wr(0, 36'h2);
        idle(1);
        wr(0, 36'h4);
        wr(0, 36'h3);
        idle(1);
        wr(0, 36'h5);
        @(posedge clock);
        offset_program_mode <= 1'h0;
        t_ne(0, 2);
        t_ne(1, 3);
    endtask

    initial begin
        rst = 1'h1;
        offset_program_mode = 1'h0;
        do_reset;
        t_reset;
        t_mail;
        t_ne(0, 8);
        t_ne(1, 8);
        t_full(9, 8);
        t_prog;
        t_full(3, 4);
        close_out;
    end
    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        close_out;
    end
endmodule // tb_bidir_fifo_flags_mailbox
`default_nettype wire
